// ===== hw/usc_params.svh
`ifndef USC_PARAMS_SVH
`define USC_PARAMS_SVH

// Register offsets on the plain register port
`define USC_ADDR_CTRL 8'h0a
`define USC_ADDR_STAT 8'h0b
`define USC_ADDR_DATA 8'h0c

// Control byte fields
`define USC_C_RECEIVE_DONE_IRQ_ENABLE 7
`define USC_C_SEND_DONE_IRQ_ENABLE 6
`define USC_C_BUFFER_EMPTY_IRQ_ENABLE 5
`define USC_C_RECEIVER_ENABLE 4
`define USC_C_TRANSMITTER_ENABLE 3
`define USC_C_NINE 2
`define USC_C_RECEIVED_NINTH_BIT 1
`define USC_C_SEND_NINTH_BIT 0
`define USC_CTRL_RST 8'h00
`define USC_CTRL_WR_MASK 8'hfd
`define USC_CTRL_RD_MASK 8'hfe

// Status byte fields
`define USC_S_RXC 7
`define USC_S_TXC 6
`define USC_S_SEND_BUFFER_EMPTY_FLAG 5
`define USC_S_FE 4
`define USC_S_OVR 3
`define USC_STAT_RST 8'h20
`define USC_STAT_RD_MASK 8'hf8

// Oversampling: sample numbers within one sixteen-tick bit period
`define USC_SAMPLE_FIRST 4'h1
`define USC_SAMPLE_A 4'h8
`define USC_SAMPLE_B 4'h9
`define USC_SAMPLE_C 4'ha
`define USC_SAMPLE_LAST 4'h0
`define USC_LAST_BIT8 4'h7
`define USC_LAST_BIT9 4'h8

// Transmit framing
`define USC_FRAME_LEN8 4'ha
`define USC_FRAME_LEN9 4'hb
`define USC_TX_PHASE_END 4'hf

`endif

// ===== hw/usc_pkg.sv
package usc_pkg;

   typedef enum logic [1:0] {
      USC_RX_IDLE,
      USC_RX_START,
      USC_RX_DATA,
      USC_RX_STOP
   } usc_rx_state_e;

   typedef struct packed {
      usc_rx_state_e state;
      logic [3:0] phase;
      logic [3:0] bit_idx;
      logic [1:0] votes;
      logic [8:0] shift;
      logic done;
      logic [8:0] data;
      logic stop_ok;
   } usc_rx_s;

   typedef struct packed {
      logic [7:0] count;
      logic tick;
   } usc_baud_s;

   typedef struct packed {
      logic [7:0] ctrl;
      logic [7:0] stat;
      logic [7:0] rx_buf;
      logic ovr_pend;
      logic [7:0] tx_hold;
      logic tx_pend;
      logic [10:0] tx_shift;
      logic [3:0] tx_bits;
      logic [3:0] tx_phase;
      logic tx_busy;
      logic txd;
      logic [7:0] rdata;
   } usc_core_s;

   function automatic logic usc_majority3(input logic [2:0] v);
      return (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
   endfunction : usc_majority3

endpackage : usc_pkg

// ===== hw/usc_rx_if.sv
`timescale 1ns/10ps
interface usc_rx_if;
   logic [7:0] divisor;
   logic tick;
   logic rx_line;
   logic rx_enable;
   logic nine_bit;
   logic done;
   logic [8:0] data;
   logic stop_ok;

   modport baud (input divisor, output tick);
   modport rx (input tick, input rx_line, input rx_enable, input nine_bit,
               output done, output data, output stop_ok);
   modport core (output divisor, output rx_line, output rx_enable, output nine_bit,
                 input tick, input done, input data, input stop_ok);
endinterface : usc_rx_if

// ===== hw/usc_baud_gen.sv
`timescale 1ns/10ps
`include "usc_params.svh"
module usc_baud_gen import usc_pkg::*; (
   input logic clk,
   input logic reset_n,
   usc_rx_if.baud link
);
   usc_baud_s q;
   usc_baud_s d;

   // Tick period is divisor plus one clocks, i.e. sixteen ticks per bit
   always_comb begin
      d = q;
      d.tick = 1'b0;
      if (q.count >= link.divisor) begin
         d.count = 8'h00;
         d.tick = 1'b1;
      end else begin
         d.count = q.count + 8'h01;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign link.tick = q.tick;
endmodule : usc_baud_gen

// ===== hw/usc_rx_sampler.sv
`timescale 1ns/10ps
`include "usc_params.svh"
module usc_rx_sampler import usc_pkg::*; (
   input logic clk,
   input logic reset_n,
   usc_rx_if.rx link
);
   usc_rx_s q;
   usc_rx_s d;
   logic [3:0] smp;
   logic vote;
   logic [3:0] last_bit;

   always_comb begin
      d = q;
      d.done = 1'b0;
      smp = q.phase + 4'h1;
      vote = usc_majority3({link.rx_line, q.votes});
      last_bit = link.nine_bit ? `USC_LAST_BIT9 : `USC_LAST_BIT8;
      if (!link.rx_enable) begin
         d.state = USC_RX_IDLE;
         d.phase = 4'h0;
      end else if (link.tick) begin
         if (q.state == USC_RX_IDLE) begin
            if (!link.rx_line) begin
               d.state = USC_RX_START;
               d.phase = `USC_SAMPLE_FIRST;
               d.shift = 9'h000;
            end
         end else begin
            d.phase = smp;
            if (smp == `USC_SAMPLE_A) begin
               d.votes[0] = link.rx_line;
            end
            if (smp == `USC_SAMPLE_B) begin
               d.votes[1] = link.rx_line;
            end
            unique case (q.state)
               USC_RX_START: begin
                  if (smp == `USC_SAMPLE_C && vote) begin
                     d.state = USC_RX_IDLE;
                  end else if (smp == `USC_SAMPLE_LAST) begin
                     d.state = USC_RX_DATA;
                     d.bit_idx = 4'h0;
                  end
               end
               USC_RX_DATA: begin
                  if (smp == `USC_SAMPLE_C) begin
                     d.shift[q.bit_idx] = vote;
                  end else if (smp == `USC_SAMPLE_LAST) begin
                     if (q.bit_idx == last_bit) begin
                        d.state = USC_RX_STOP;
                     end else begin
                        d.bit_idx = q.bit_idx + 4'h1;
                     end
                  end
               end
               USC_RX_STOP: begin
                  // Ends at the third sample so a back-to-back start is not missed
                  if (smp == `USC_SAMPLE_C) begin
                     d.done = 1'b1;
                     d.data = q.shift;
                     d.stop_ok = vote;
                     d.state = USC_RX_IDLE;
                  end
               end
               USC_RX_IDLE: begin
               end
            endcase
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign link.done = q.done;
   assign link.data = q.data;
   assign link.stop_ok = q.stop_ok;
endmodule : usc_rx_sampler

// ===== hw/usc_uart_rx_ctrl.sv
//
// Contract
// - Sample line at sixteen times bit rate
// - Single low sample starts candidate start
// - Majority high at 8,9,10 rejects start
// - Data bits majority-voted at samples 8-10
// - Stop majority low sets frame error
// - Character loads buffer, sets receive-done unless buffer unread
// - Data address: read receive, write transmit
// - Nine-bit mode loads received ninth bit
// - Unread buffer loses new char; overrun deferred
// - Successful transfer clears overrun flag
// - Receiver enable forces pin input, pull-up kept
// - Reading buffer clears receive-done; level request
// - Send-done on idle; cleared by vector, write-one
// - Buffer-empty set on load, cleared on write
// - Buffer-empty high during and after reset
// - Buffer-empty request is a level
// - High stop bit clears frame error
// - Each request needs own and global enable
// - Receiver off blocks send-done, overrun, frame-error
// - Transmitter drains shift and pending on disable
// - Nine-bit option carries nine data bits
// - Low three status bits read zero
// - Rate is clock over sixteen times divisor+1
// - Send ninth bit feeds next transmitted char
//
`timescale 1ns/10ps
`include "usc_params.svh"
module usc_uart_rx_ctrl import usc_pkg::*; (
   input logic clk,
   input logic reset_n,
   input logic [7:0] reg_addr,
   input logic [7:0] reg_wdata,
   input logic reg_wr,
   input logic reg_rd,
   output logic [7:0] reg_rdata,
   input logic [7:0] bit_rate_divisor,
   input logic global_irq_enable,
   input logic send_done_vector_taken,
   input logic receive_port_pin_in,
   output logic receive_port_pin_out,
   output logic receive_port_pin_oe,
   output logic receive_port_pin_pullup_en,
   input logic receive_pin_direction,
   input logic receive_pin_pullup,
   output logic send_port_pin_out,
   output logic send_port_pin_oe,
   output logic receive_done_irq,
   output logic send_done_irq,
   output logic buffer_empty_irq
);

   ////////////////////////////////////////////////////////////////////////////////

   localparam usc_core_s CORE_RST = '{
      ctrl: `USC_CTRL_RST,
      stat: `USC_STAT_RST,
      txd: 1'b1,
      default: '0
   };

   usc_core_s q;
   usc_core_s d;
   usc_rx_if link();

   logic rx_en;
   logic tx_en;
   logic nine;
   logic rd_data;
   logic wr_data;
   logic wr_ctrl;
   logic wr_stat;
   logic tx_tick_end;
   logic tx_char_end;
   logic tx_load;
   logic [10:0] tx_frame;

   ////////////////////////////////////////////////////////////////////////////////
   // Receive front end and bit-rate divider

   assign link.divisor = bit_rate_divisor;
   // Disabled receiver sees an idle line, so it never starts a character
   assign link.rx_line = rx_en ? receive_port_pin_in : 1'b1;
   assign link.rx_enable = rx_en;
   assign link.nine_bit = nine;

   usc_baud_gen u_baud (
      .clk(clk),
      .reset_n(reset_n),
      .link(link)
   );

   usc_rx_sampler u_rx (
      .clk(clk),
      .reset_n(reset_n),
      .link(link)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Decode

   assign rx_en = q.ctrl[`USC_C_RECEIVER_ENABLE];
   assign tx_en = q.ctrl[`USC_C_TRANSMITTER_ENABLE];
   assign nine = q.ctrl[`USC_C_NINE];
   assign rd_data = reg_rd && (reg_addr == `USC_ADDR_DATA);
   assign wr_data = reg_wr && (reg_addr == `USC_ADDR_DATA);
   assign wr_ctrl = reg_wr && (reg_addr == `USC_ADDR_CTRL);
   assign wr_stat = reg_wr && (reg_addr == `USC_ADDR_STAT);

   // Transmit timing: one bit is sixteen ticks of the shared divider
   assign tx_tick_end = q.tx_busy && link.tick && (q.tx_phase == `USC_TX_PHASE_END);
   assign tx_char_end = tx_tick_end && (q.tx_bits == 4'h1);
   // A character already in flight keeps the link going after disable
   assign tx_load = q.tx_pend && ((!q.tx_busy && tx_en) || tx_char_end);
   // Stop bit, optional ninth bit, data LSB first, start bit
   assign tx_frame = {1'b1, nine ? q.ctrl[`USC_C_SEND_NINTH_BIT] : 1'b1, q.tx_hold, 1'b0};

   ////////////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      d = q;

      // Transmit shifter
      if (q.tx_busy && link.tick) begin
         d.tx_phase = q.tx_phase + 4'h1;
      end
      if (tx_tick_end) begin
         if (q.tx_bits == 4'h1) begin
            d.tx_busy = 1'b0;
            d.txd = 1'b1;
            if (!q.tx_pend && rx_en) begin
               d.stat[`USC_S_TXC] = 1'b1;
            end
         end else begin
            d.tx_shift = {1'b1, q.tx_shift[10:1]};
            d.txd = q.tx_shift[1];
            d.tx_bits = q.tx_bits - 4'h1;
         end
      end
      if (tx_load) begin
         d.tx_shift = tx_frame;
         d.txd = tx_frame[0];
         d.tx_bits = nine ? `USC_FRAME_LEN9 : `USC_FRAME_LEN8;
         d.tx_phase = 4'h0;
         d.tx_busy = 1'b1;
         d.tx_pend = 1'b0;
         d.stat[`USC_S_SEND_BUFFER_EMPTY_FLAG] = 1'b1;
      end

      // Send-done clears; a set in the same cycle wins
      if ((send_done_vector_taken || (wr_stat && reg_wdata[`USC_S_TXC])) &&
          !(tx_char_end && !q.tx_pend && rx_en)) begin
         d.stat[`USC_S_TXC] = 1'b0;
      end

      // Software writes
      if (wr_data) begin
         d.tx_hold = reg_wdata;
         d.tx_pend = 1'b1;
         d.stat[`USC_S_SEND_BUFFER_EMPTY_FLAG] = 1'b0;
      end
      if (wr_ctrl) begin
         d.ctrl = (reg_wdata & `USC_CTRL_WR_MASK) | (q.ctrl & ~`USC_CTRL_WR_MASK);
      end

      // Reading the buffer reveals a deferred overrun
      if (rd_data) begin
         d.stat[`USC_S_RXC] = 1'b0;
         d.stat[`USC_S_OVR] = q.ovr_pend;
         d.ovr_pend = 1'b0;
      end

      // Character arrival; ordered after the read so the set wins
      if (link.done) begin
         if (q.stat[`USC_S_RXC] && !rd_data) begin
            d.ovr_pend = 1'b1;
         end else begin
            d.rx_buf = link.data[7:0];
            d.stat[`USC_S_RXC] = 1'b1;
            d.stat[`USC_S_FE] = !link.stop_ok;
            d.stat[`USC_S_OVR] = 1'b0;
            d.ovr_pend = 1'b0;
            if (nine) begin
               d.ctrl[`USC_C_RECEIVED_NINTH_BIT] = link.data[8];
            end
         end
      end

      // Read data stands for exactly one cycle after the strobe
      d.rdata = 8'h00;
      if (reg_rd) begin
         unique case (reg_addr)
            `USC_ADDR_DATA: d.rdata = q.rx_buf;
            `USC_ADDR_STAT: d.rdata = q.stat & `USC_STAT_RD_MASK;
            `USC_ADDR_CTRL: d.rdata = q.ctrl & `USC_CTRL_RD_MASK;
            default: d.rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         q <= CORE_RST;
      end else begin
         q <= d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs

   assign reg_rdata = q.rdata;

   // Receiver owns the pin as input; otherwise it is ordinary port logic
   assign receive_port_pin_oe = !rx_en && receive_pin_direction;
   assign receive_port_pin_out = receive_pin_pullup;
   assign receive_port_pin_pullup_en = receive_pin_pullup && !receive_port_pin_oe;

   assign send_port_pin_out = q.txd;
   assign send_port_pin_oe = tx_en || q.tx_busy;

   // Level requests: they persist while their flag, own enable and global enable all stay set
   assign receive_done_irq = q.stat[`USC_S_RXC] && q.ctrl[`USC_C_RECEIVE_DONE_IRQ_ENABLE] &&
                             global_irq_enable;
   assign send_done_irq = q.stat[`USC_S_TXC] && q.ctrl[`USC_C_SEND_DONE_IRQ_ENABLE] &&
                          global_irq_enable;
   assign buffer_empty_irq = q.stat[`USC_S_SEND_BUFFER_EMPTY_FLAG] && q.ctrl[`USC_C_BUFFER_EMPTY_IRQ_ENABLE] &&
                             global_irq_enable;

endmodule : usc_uart_rx_ctrl

// ===== bench/usc_uart_rx_ctrl_checker.sv
`timescale 1ns/10ps
`include "usc_params.svh"
module usc_uart_rx_ctrl_checker import usc_pkg::*; (
   input logic clk,
   input logic reset_n,
   input logic [7:0] reg_addr,
   input logic [7:0] reg_wdata,
   input logic reg_wr,
   input logic reg_rd,
   input logic [7:0] reg_rdata,
   input logic global_irq_enable,
   input logic send_done_vector_taken,
   input logic receive_port_pin_out,
   input logic receive_port_pin_oe,
   input logic receive_port_pin_pullup_en,
   input logic receive_pin_direction,
   input logic receive_pin_pullup,
   input logic send_port_pin_out,
   input logic send_port_pin_oe,
   input logic receive_done_irq,
   input logic send_done_irq,
   input logic buffer_empty_irq
);
   // Shadow of the control byte, so enables can be judged from the ports alone
   logic [7:0] ctrl_q;
   logic [7:0] ctrl_d;
   always_comb begin
      ctrl_d = ctrl_q;
      if (reg_wr && reg_addr == `USC_ADDR_CTRL) begin
         ctrl_d = reg_wdata;
      end
   end
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl_q <= 8'h00;
      end else begin
         ctrl_q <= ctrl_d;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   sequence data_read_s;
      reg_rd && reg_addr == `USC_ADDR_DATA;
   endsequence
   sequence stat_read_s;
      reg_rd && reg_addr == `USC_ADDR_STAT;
   endsequence
   pin_dir_a: assert property (
      receive_port_pin_oe == (!ctrl_q[4] && receive_pin_direction)) else $error("pin dir");
   pin_pullup_a: assert property (
      receive_port_pin_pullup_en == (receive_pin_pullup && !receive_port_pin_oe)
      && receive_port_pin_out == receive_pin_pullup) else $error("pull-up");
   stat_low_a: assert property (stat_read_s |=> reg_rdata[2:0] == 3'h0)
      else $error("status low bits");
   rx_gate_a: assert property (receive_done_irq |-> global_irq_enable && ctrl_q[7])
      else $error("rx irq gate");
   tx_gate_a: assert property (send_done_irq |-> global_irq_enable && ctrl_q[6])
      else $error("tx irq gate");
   empty_gate_a: assert property (buffer_empty_irq |-> global_irq_enable && ctrl_q[5])
      else $error("empty irq gate");
   rx_clear_a: assert property (data_read_s |=> !receive_done_irq)
      else $error("rx flag kept");
   empty_clear_a: assert property (
      reg_wr && reg_addr == `USC_ADDR_DATA |=> !buffer_empty_irq) else $error("empty kept");
   tx_idle_a: assert property (!send_port_pin_oe |-> send_port_pin_out)
      else $error("tx not idle");
   send_receiver_enable_a: assert property (
      $rose(send_done_irq) && $stable(ctrl_q) && $stable(global_irq_enable) |-> ctrl_q[4])
      else $error("tx done w/o rx");
   vector_clr_a: assert property (send_done_vector_taken |=> !send_done_irq)
      else $error("vector clear");
endmodule : usc_uart_rx_ctrl_checker

bind usc_uart_rx_ctrl usc_uart_rx_ctrl_checker u_checker (.clk(clk), .reset_n(reset_n),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .global_irq_enable(global_irq_enable),
   .send_done_vector_taken(send_done_vector_taken),
   .receive_port_pin_out(receive_port_pin_out), .receive_port_pin_oe(receive_port_pin_oe),
   .receive_port_pin_pullup_en(receive_port_pin_pullup_en),
   .receive_pin_direction(receive_pin_direction), .receive_pin_pullup(receive_pin_pullup),
   .send_port_pin_out(send_port_pin_out), .send_port_pin_oe(send_port_pin_oe),
   .receive_done_irq(receive_done_irq), .send_done_irq(send_done_irq),
   .buffer_empty_irq(buffer_empty_irq));

// ===== bench/usc_remote_dev.sv
`timescale 1ns/10ps
module usc_remote_dev (
   input logic clk,
   input logic tx_line,
   output logic rx_line
);
   // Line has a pull-up, so a released line idles high
   initial rx_line = 1'b1;
   // Whole frame: start, data LSB first, optional ninth bit, stop; bc clocks per bit
   task automatic send(input logic [8:0] d, input logic nine, input logic stop, input int bc);
      logic [10:0] f;
      int n;
      f = nine ? {stop, d, 1'b0} : {1'b0, stop, d[7:0], 1'b0};
      n = nine ? 11 : 10;
      for (int i = 0; i < n; i++) begin
         @(posedge clk);
         rx_line <= f[i];
         repeat (bc - 1) @(posedge clk);
      end
      @(posedge clk);
      rx_line <= 1'b1;
      repeat (2 * bc) @(posedge clk);
   endtask : send
   task automatic glitch(input int len);
      @(posedge clk);
      rx_line <= 1'b0;
      repeat (len) @(posedge clk);
      rx_line <= 1'b1;
      repeat (40) @(posedge clk);
   endtask : glitch
   // Samples mid-bit at sixteen clocks per bit
   task automatic catch_char(output logic [7:0] d);
      @(negedge tx_line);
      repeat (8) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
         repeat (16) @(posedge clk);
         d[i] = tx_line;
      end
   endtask : catch_char
endmodule : usc_remote_dev

// ===== bench/usc_uart_rx_ctrl_bench.sv
`timescale 1ns/10ps
`include "usc_params.svh"
module usc_uart_rx_ctrl_bench;
   import usc_pkg::*;
   logic clk = 1'b0;
   logic reset_n;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   logic [7:0] bit_rate_divisor = 8'h00;
   logic global_irq_enable = 1'b0;
   logic vec = 1'b0;
   logic remote_line;
   logic pin_wire;
   logic pin_out;
   logic pin_oe;
   logic tx_pin;
   logic rx_irq;
   logic tx_irq;
   logic empty_irq;
   int n_fail = 0;
   int check_count = 0;
   logic [7:0] got;
   always #2 clk = ~clk;
   assign pin_wire = pin_oe ? pin_out : remote_line;
   usc_uart_rx_ctrl u_usc_uart_rx_ctrl (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .bit_rate_divisor(bit_rate_divisor), .global_irq_enable(global_irq_enable),
      .send_done_vector_taken(vec), .receive_port_pin_in(pin_wire),
      .receive_port_pin_out(pin_out), .receive_port_pin_oe(pin_oe),
      .receive_port_pin_pullup_en(), .receive_pin_direction(1'b1), .receive_pin_pullup(1'b1),
      .send_port_pin_out(tx_pin), .send_port_pin_oe(), .receive_done_irq(rx_irq),
      .send_done_irq(tx_irq), .buffer_empty_irq(empty_irq));
   usc_remote_dev u_usc_remote_dev (.clk(clk), .tx_line(tx_pin), .rx_line(remote_line));
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rdc(input logic [7:0] a, input logic [7:0] exp, input string nm);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 chk(nm, reg_rdata, exp);
   endtask : rdc
   task automatic end_sim;
      $display("checks %0d fails %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : end_sim
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      rdc(`USC_ADDR_CTRL, 8'h00, "ctrl");
      rdc(`USC_ADDR_STAT, 8'h20, "stat");
      rdc(8'h0d, 8'h00, "unmapped");
      $display("reset done");
   endtask : t_reset
   task automatic t_rx;
      wr(`USC_ADDR_CTRL, 8'h10);
      u_usc_remote_dev.send(9'h0a5, 1'b0, 1'b1, 16);
      rdc(`USC_ADDR_STAT, 8'ha0, "stat");
      rdc(`USC_ADDR_DATA, 8'ha5, "data");
      rdc(`USC_ADDR_STAT, 8'h20, "stat");
      u_usc_remote_dev.glitch(5);
      rdc(`USC_ADDR_STAT, 8'h20, "glitch");
      $display("rx done");
   endtask : t_rx
   task automatic t_frame;
      u_usc_remote_dev.send(9'h03c, 1'b0, 1'b0, 16);
      repeat (40) @(posedge clk);
      rdc(`USC_ADDR_STAT, 8'hb0, "stat");
      rdc(`USC_ADDR_DATA, 8'h3c, "data");
      u_usc_remote_dev.send(9'h055, 1'b0, 1'b1, 16);
      rdc(`USC_ADDR_STAT, 8'ha0, "stat");
      rdc(`USC_ADDR_DATA, 8'h55, "data");
      $display("frame done");
   endtask : t_frame
   task automatic t_overrun;
      u_usc_remote_dev.send(9'h011, 1'b0, 1'b1, 16);
      u_usc_remote_dev.send(9'h022, 1'b0, 1'b1, 16);
      rdc(`USC_ADDR_STAT, 8'ha0, "stat");
      rdc(`USC_ADDR_DATA, 8'h11, "data");
      rdc(`USC_ADDR_STAT, 8'h28, "stat");
      u_usc_remote_dev.send(9'h033, 1'b0, 1'b1, 16);
      rdc(`USC_ADDR_STAT, 8'ha0, "stat");
      rdc(`USC_ADDR_DATA, 8'h33, "data");
      $display("overrun done");
   endtask : t_overrun
   task automatic t_nine;
      wr(`USC_ADDR_CTRL, 8'h14);
      u_usc_remote_dev.send(9'h1c3, 1'b1, 1'b1, 16);
      rdc(`USC_ADDR_CTRL, 8'h16, "ctrl");
      rdc(`USC_ADDR_DATA, 8'hc3, "data");
      wr(`USC_ADDR_CTRL, 8'h10);
      bit_rate_divisor <= 8'h01;
      u_usc_remote_dev.send(9'h096, 1'b0, 1'b1, 32);
      rdc(`USC_ADDR_DATA, 8'h96, "slow");
      bit_rate_divisor <= 8'h00;
      $display("nine done");
   endtask : t_nine
   task automatic t_irq;
      global_irq_enable <= 1'b1;
      wr(`USC_ADDR_CTRL, 8'hb0);
      #1 chk("empty", {7'h00, empty_irq}, 8'h01);
      u_usc_remote_dev.send(9'h042, 1'b0, 1'b1, 16);
      chk("rxirq", {7'h00, rx_irq}, 8'h01);
      @(posedge clk);
      global_irq_enable <= 1'b0;
      #1 chk("rxirq", {7'h00, rx_irq}, 8'h00);
      global_irq_enable <= 1'b1;
      rdc(`USC_ADDR_DATA, 8'h42, "data");
      #1 chk("rxirq", {7'h00, rx_irq}, 8'h00);
      wr(`USC_ADDR_CTRL, 8'h58);
      wr(`USC_ADDR_DATA, 8'h5a);
      u_usc_remote_dev.catch_char(got);
      chk("txchar", got, 8'h5a);
      repeat (40) @(posedge clk);
      rdc(`USC_ADDR_STAT, 8'h60, "stat");
      chk("txirq", {7'h00, tx_irq}, 8'h01);
      @(posedge clk);
      vec <= 1'b1;
      @(posedge clk);
      vec <= 1'b0;
      rdc(`USC_ADDR_STAT, 8'h20, "stat");
      $display("irq done");
   endtask : t_irq
   ////////////////////////////////////////////////////////////////////////////
   // Reset is asserted by a non-blocking assignment at time zero so the asynchronous reset sees a falling edge
   initial begin
      reset_n <= 1'b0;
      repeat (4) @(posedge clk);
      reset_n <= 1'b1;
      t_reset();
      t_rx();
      t_frame();
      t_overrun();
      t_nine();
      t_irq();
      end_sim();
   end
   // Whole run is about 2300 clocks; a hang is cut off well beyond that
   initial begin
      #100000;
      n_fail++;
      end_sim();
   end
endmodule : usc_uart_rx_ctrl_bench
